// *** core/ndw_pkg.sv ***
// Package for the downstream window setup register bank: offsets, fields, types
package ndw_pkg;

    localparam int ADDR_W = 12;

    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [ADDR_W-1:0] OFF_W2_TBASE = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_W2_SETUP = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_W3_TBASE = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_W3_SETUP = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_W3_UPPER = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_RSVD_LO = 12'h01C;
    localparam logic [ADDR_W-1:0] OFF_RSVD_HI = 12'h030;

    // ************************************************
    // Field positions and write masks
    // ************************************************
    localparam int TYPE_BIT = 0;
    localparam int ATYPE_LSB = 1;
    localparam int ATYPE_MSB = 2;
    localparam int PREF_BIT = 3;
    localparam int SIZE_LSB = 12;
    localparam int SIZE_MSB = 30;
    localparam int EN_BIT = 31;
    localparam logic [1:0] ATYPE_32 = 2'h0;
    localparam logic [1:0] ATYPE_64 = 2'h1;
    localparam logic [31:0] SETUP_INIT_WMASK = 32'hFFFFF00E;
    localparam logic [31:0] TBASE_WMASK = 32'hFFFFF000;
    localparam logic [31:0] UPPER_WMASK = 32'hFFFFFFFF;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [31:0] RST_TBASE = 32'h00000000;
    localparam logic [31:0] RST_SETUP = 32'h00000000;
    localparam logic [31:0] RST_UPPER = 32'h00000000;

    // ************************************************
    // Carriers
    // ************************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } ndw_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } ndw_resp_t;

    typedef struct packed {
        logic valid;
        logic win3;
        logic [31:0] addr;
    } ndw_xlt_req_t;

    typedef struct packed {
        logic valid;
        logic hit_en;
        logic [31:0] addr;
    } ndw_xlt_resp_t;

endpackage : ndw_pkg

// *** core/ndw_down_win.sv ***
// Downstream window 2/3 setup and translated base registers with address translation
//
// Operation
// R1 - Bit 0 of every downstream window setup register reads as zero, asking for memory space; the window 3 upper setup has bit 0 bus-writable instead.
// R2 - Setup bits 2:1 give the address width, 00 for 32-bit and 01 for 64-bit, reset 00.
// R3 - Setup bits 30:12 mark which base address bits are writable, setting the size, reset 0.
// R4 - Setup bit 31 enables the window base address register, reset 0.
// R5 - Window 3 translated base bits 31:12 are writable and hold the replacement base, reset 0.
// R6 - The window 3 setup size mask decides how many translated base bits are used.
// R7 - The window 3 upper setup holds a bus-writable size mask for the upper base, reset 0.
// R8 - The window 3 upper setup bit 31 is a writable 64-bit base enable, reset 0.
// R9 - Offsets 01Ch to 030h hold nothing, read zero, and writes there do nothing.
// R10 - Both the primary and the secondary port can reach the registers.
// R11 - Window 2 translated base bits 31:12 replace the bits selected by its size mask.
// R12 - A hit swaps the masked upper address bits for the base and keeps the offset bits.
// R13 - Bus read-only setup fields can still be loaded through the initialization path.
`timescale 1ns/1ns
module ndw_down_win
    import ndw_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire ndw_req_t P_REQ,
    output logic P_READY,
    output ndw_resp_t P_RESP,
    input wire ndw_req_t S_REQ,
    output logic S_READY,
    output ndw_resp_t S_RESP,
    input wire logic INIT_WE,
    input wire logic [ADDR_W-1:0] INIT_ADDR,
    input wire logic [31:0] INIT_DATA,
    input wire ndw_xlt_req_t XLT_REQ,
    output ndw_xlt_resp_t XLT_RESP,
    output logic [31:0] W2_SETUP,
    output logic [31:0] W3_SETUP,
    output logic [31:0] W3_UPPER_SETUP
);

    // ************************************************
    // Port arbitration
    // ************************************************
    // Primary always wins a tie; the secondary waits for as long as the primary stays valid.
    // Secondary ready is combinational, so a waiting request goes in as soon as the primary drops.
    logic take_p;
    logic take_s;
    ndw_req_t req;
    logic acc;
    logic wr;
    logic [31:0] be_mask;

    assign take_p = P_REQ.valid;
    assign take_s = S_REQ.valid && !P_REQ.valid; // [R10]
    assign P_READY = 1'b1;
    assign S_READY = !P_REQ.valid;
    assign req = take_p ? P_REQ : S_REQ;
    assign acc = CE && (take_p || take_s);
    assign wr = acc && req.write;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_be
            assign be_mask[8*gi +: 8] = {8{req.be[gi]}};
        end
    endgenerate

    // ************************************************
    // Address decode
    // ************************************************
    logic sel_w2_tbase;
    logic sel_w2_setup;
    logic sel_w3_tbase;
    logic sel_w3_setup;
    logic sel_w3_upper;
    logic sel_rsvd;

    // The reserved range decode only feeds the checks; the read mux defaults to zero.
    assign sel_w2_tbase = req.addr == OFF_W2_TBASE;
    assign sel_w2_setup = req.addr == OFF_W2_SETUP;
    assign sel_w3_tbase = req.addr == OFF_W3_TBASE;
    assign sel_w3_setup = req.addr == OFF_W3_SETUP;
    assign sel_w3_upper = req.addr == OFF_W3_UPPER;
    assign sel_rsvd = (req.addr >= OFF_RSVD_LO) && (req.addr <= OFF_RSVD_HI);

    // ************************************************
    // Register storage and next values
    // ************************************************
    logic [31:0] win2_tbase;
    logic [31:0] win2_setup;
    logic [31:0] win3_tbase;
    logic [31:0] win3_setup;
    logic [31:0] win3_upper;
    logic [31:0] next_win2_tbase;
    logic [31:0] next_win2_setup;
    logic [31:0] next_win3_tbase;
    logic [31:0] next_win3_setup;
    logic [31:0] next_win3_upper;
    logic [31:0] bus_tmask;
    logic [31:0] bus_umask;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    assign bus_tmask = TBASE_WMASK & be_mask;
    assign bus_umask = UPPER_WMASK & be_mask;

    // The loader has priority over a bus write landing in the same cycle.
    // The window 2 and 3 setup registers take no bus write at all; only the loader fills them.
    assign next_win2_setup = (INIT_WE && INIT_ADDR == OFF_W2_SETUP) ?
        merge(win2_setup, INIT_DATA, SETUP_INIT_WMASK) : win2_setup; // [R13] [R1]
    assign next_win3_setup = (INIT_WE && INIT_ADDR == OFF_W3_SETUP) ?
        merge(win3_setup, INIT_DATA, SETUP_INIT_WMASK) : win3_setup; // [R13] [R1]
    assign next_win2_tbase = (INIT_WE && INIT_ADDR == OFF_W2_TBASE) ?
        merge(win2_tbase, INIT_DATA, TBASE_WMASK) :
        (wr && sel_w2_tbase) ? merge(win2_tbase, req.wdata, bus_tmask) : win2_tbase; // [R11]
    assign next_win3_tbase = (INIT_WE && INIT_ADDR == OFF_W3_TBASE) ?
        merge(win3_tbase, INIT_DATA, TBASE_WMASK) :
        (wr && sel_w3_tbase) ? merge(win3_tbase, req.wdata, bus_tmask) : win3_tbase; // [R5]
    assign next_win3_upper = (INIT_WE && INIT_ADDR == OFF_W3_UPPER) ?
        merge(win3_upper, INIT_DATA, UPPER_WMASK) :
        (wr && sel_w3_upper) ? merge(win3_upper, req.wdata, bus_umask) : win3_upper; // [R7] [R8]

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            win2_tbase <= RST_TBASE;
            win2_setup <= RST_SETUP; // [R2] [R3] [R4]
            win3_tbase <= RST_TBASE; // [R5]
            win3_setup <= RST_SETUP; // [R2] [R3] [R4]
            win3_upper <= RST_UPPER; // [R7] [R8]
        end else if (CE) begin
            win2_tbase <= next_win2_tbase;
            win2_setup <= next_win2_setup;
            win3_tbase <= next_win3_tbase;
            win3_setup <= next_win3_setup;
            win3_upper <= next_win3_upper;
        end
    end

    // ************************************************
    // Read data and answers
    // ************************************************
    logic [31:0] rd_mux;

    // Unmapped and reserved offsets read zero and ignore writes.
    always_comb begin
        if (sel_w2_tbase) begin
            rd_mux = win2_tbase;
        end else if (sel_w2_setup) begin
            rd_mux = win2_setup;
        end else if (sel_w3_tbase) begin
            rd_mux = win3_tbase;
        end else if (sel_w3_setup) begin
            rd_mux = win3_setup;
        end else if (sel_w3_upper) begin
            rd_mux = win3_upper;
        end else begin
            rd_mux = 32'h00000000; // [R9]
        end
    end

    // Read data is registered on every enabled cycle, so it only means something with an ack.
    logic p_ack;
    logic s_ack;
    logic [31:0] rdata;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            p_ack <= 1'b0;
            s_ack <= 1'b0;
            rdata <= 32'h00000000;
        end else if (CE) begin
            p_ack <= take_p;
            s_ack <= take_s; // [R10]
            rdata <= rd_mux;
        end
    end

    assign P_RESP = '{ack: p_ack, rdata: rdata};
    assign S_RESP = '{ack: s_ack, rdata: rdata};
    assign W2_SETUP = win2_setup;
    assign W3_SETUP = win3_setup;
    assign W3_UPPER_SETUP = win3_upper;

    // ************************************************
    // Address translation
    // ************************************************
    // Bit 31 is always base; bits 30:12 follow the size mask; 11:0 is offset.
    // Only 32-bit translation lives here; the upper setup is stored for the 64-bit path.
    logic [31:0] mask2;
    logic [31:0] mask3;
    logic [31:0] sel_mask;
    logic [31:0] sel_tbase;
    logic sel_en;
    logic [31:0] xlt_addr;
    logic xlt_valid;
    logic xlt_hit;

    assign mask2 = {1'b1, win2_setup[SIZE_MSB:SIZE_LSB], 12'h000}; // [R11]
    assign mask3 = {1'b1, win3_setup[SIZE_MSB:SIZE_LSB], 12'h000}; // [R6]
    assign sel_mask = XLT_REQ.win3 ? mask3 : mask2;
    assign sel_tbase = XLT_REQ.win3 ? win3_tbase : win2_tbase;
    assign sel_en = XLT_REQ.win3 ? win3_setup[EN_BIT] : win2_setup[EN_BIT]; // [R4]

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            xlt_valid <= 1'b0;
            xlt_hit <= 1'b0;
            xlt_addr <= 32'h00000000;
        end else if (CE) begin
            xlt_valid <= XLT_REQ.valid;
            xlt_hit <= XLT_REQ.valid && sel_en;
            xlt_addr <= sel_en ? merge(XLT_REQ.addr, sel_tbase, sel_mask) : XLT_REQ.addr; // [R12]
        end
    end

    assign XLT_RESP = '{valid: xlt_valid, hit_en: xlt_hit, addr: xlt_addr};

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    type_bit_zero_a: assert property (!W2_SETUP[TYPE_BIT] && !W3_SETUP[TYPE_BIT]) // [R1]
        else $error("setup type bit not zero");

    init_load_a: assert property (CE && INIT_WE && INIT_ADDR == OFF_W3_SETUP |=> // [R13]
        W3_SETUP[ATYPE_MSB:ATYPE_LSB] == $past(INIT_DATA[ATYPE_MSB:ATYPE_LSB])
        && W3_SETUP[EN_BIT] == $past(INIT_DATA[EN_BIT]))
        else $error("loader did not fill setup fields");

    setup_bus_ro_a: assert property (wr && sel_w2_setup && !INIT_WE |=> $stable(W2_SETUP)) // [R3]
        else $error("bus write changed a setup register");

    tbase_write_a: assert property (wr && sel_w3_tbase && req.be == 4'hF && !INIT_WE |=> // [R5]
        win3_tbase == ($past(req.wdata) & TBASE_WMASK))
        else $error("translated base write wrong");

    upper_write_a: assert property (wr && sel_w3_upper && req.be == 4'hF && !INIT_WE |=> // [R7]
        W3_UPPER_SETUP == $past(req.wdata))
        else $error("upper setup write wrong");

    rsvd_quiet_a: assert property (wr && sel_rsvd && !INIT_WE |=> // [R9]
        $stable(win2_tbase) && $stable(win3_tbase) && $stable(W3_UPPER_SETUP)
        ##0 P_RESP.rdata == 32'h00000000)
        else $error("reserved offset had an effect");

    sec_served_a: assert property (CE && S_REQ.valid && !P_REQ.valid |=> // [R10]
        S_RESP.ack && !P_RESP.ack)
        else $error("secondary request not answered");

    disabled_pass_a: assert property (CE && XLT_REQ.valid && !sel_en |=> // [R4]
        XLT_RESP.valid && !XLT_RESP.hit_en && XLT_RESP.addr == $past(XLT_REQ.addr))
        else $error("disabled window translated");

    win3_xlt_a: assert property (CE && XLT_REQ.valid && XLT_REQ.win3 && sel_en |=> // [R6]
        XLT_RESP.hit_en && XLT_RESP.addr ==
        (($past(XLT_REQ.addr) & ~$past(mask3)) | ($past(win3_tbase) & $past(mask3))))
        else $error("window 3 translation wrong");

    offset_kept_a: assert property (CE && XLT_REQ.valid |=> // [R12]
        XLT_RESP.addr[11:0] == $past(XLT_REQ.addr[11:0]))
        else $error("offset bits altered");

    tbase2_write_a: assert property (wr && sel_w2_tbase && req.be == 4'hF && !INIT_WE |=> // [R11]
        win2_tbase == ($past(req.wdata) & TBASE_WMASK))
        else $error("window 2 translated base write wrong");

    tbase_low_a: assert property (win2_tbase[SIZE_LSB-1:0] == '0 && // [R5] [R11]
        win3_tbase[SIZE_LSB-1:0] == '0)
        else $error("translated base low bits not zero");

    w3_setup_ro_a: assert property (wr && sel_w3_setup && !INIT_WE |=> // [R3]
        $stable(W3_SETUP))
        else $error("bus write changed window 3 setup");

    win2_xlt_a: assert property (CE && XLT_REQ.valid && !XLT_REQ.win3 && sel_en |=> // [R11]
        XLT_RESP.hit_en && XLT_RESP.addr ==
        (($past(XLT_REQ.addr) & ~$past(mask2)) | ($past(win2_tbase) & $past(mask2))))
        else $error("window 2 translation wrong");

    prim_ack_a: assert property (CE && P_REQ.valid |=> P_RESP.ack && !S_RESP.ack) // [R10]
        else $error("primary request not answered");

    read_data_a: assert property (CE && P_REQ.valid && !P_REQ.write && // [R7]
        P_REQ.addr == OFF_W3_UPPER |=> P_RESP.rdata == $past(W3_UPPER_SETUP))
        else $error("upper setup read back wrong");

    upper_en_a: assert property (wr && sel_w3_upper && req.be[3] && !INIT_WE |=> // [R8]
        W3_UPPER_SETUP[EN_BIT] == $past(req.wdata[EN_BIT]))
        else $error("upper enable bit write wrong");

    ce_hold_a: assert property (!CE |=> $stable(W3_UPPER_SETUP) && $stable(P_RESP) && // [R7]
        $stable(XLT_RESP))
        else $error("state moved with clock enable low");

    prim_read_c: cover property (CE && P_REQ.valid && !P_REQ.write ##1 P_RESP.ack);
    ce_low_c: cover property (!CE && INIT_WE);
    both_req_c: cover property (CE && P_REQ.valid && S_REQ.valid ##1 CE && S_REQ.valid);
    w3_hit_c: cover property (CE && XLT_REQ.valid && XLT_REQ.win3 && sel_en);
    upper_en_c: cover property (W3_UPPER_SETUP[EN_BIT]);

endmodule : ndw_down_win

// *** verification/ndw_host.sv ***
// Bus initiator model that stands on the primary and secondary ports
`timescale 1ns/1ns
module ndw_host
    import ndw_pkg::*;
(
    input wire logic clk,
    output ndw_req_t p_req,
    input wire logic p_ready,
    input wire ndw_resp_t p_resp,
    output ndw_req_t s_req,
    input wire logic s_ready,
    input wire ndw_resp_t s_resp
);
    initial begin
        p_req = '0;
        s_req = '0;
    end

    // Either port may reach the registers; the request is held until taken
    task automatic acc(input logic sec, input logic [ADDR_W-1:0] a, input logic [3:0] be,
            input logic [31:0] d, input logic wr, output logic [31:0] rd, output logic ok);
        ndw_req_t r;
        int n;
        r = '{valid: 1'h1, write: wr, addr: a, be: be, wdata: d};
        n = 0;
        @(posedge clk);
        #1;
        if (sec) s_req = r;
        else p_req = r;
        do begin
            @(posedge clk);
            n++;
        end while (!(sec ? s_ready : p_ready) && n < 8);
        #1;
        // Released lines show the inverse so a stale value never looks valid
        r = '{valid: 1'h0, write: ~wr, addr: ~a, be: ~be, wdata: ~d};
        if (sec) s_req = r;
        else p_req = r;
        @(posedge clk);
        ok = ((sec ? s_resp.ack : p_resp.ack) === 1'h1) && (n < 8);
        rd = sec ? s_resp.rdata : p_resp.rdata;
    endtask : acc
endmodule : ndw_host

// *** verification/testbench.sv ***
// Self-checking bench for the downstream window setup register bank
`timescale 1ns/1ns
module testbench;
    import ndw_pkg::*;
    typedef struct {
        logic sec;
        logic [ADDR_W-1:0] a;
        logic [3:0] be;
        logic [31:0] d;
        logic [31:0] e;
    } ndw_row_t;
    logic ref_clk, rst, ce, init_we, ok, ok2;
    logic [ADDR_W-1:0] init_addr;
    logic [31:0] init_data, rd, rd2, w2_setup, w3_setup, w3_upper;
    ndw_req_t p_req, s_req;
    ndw_resp_t p_resp, s_resp;
    logic p_ready, s_ready;
    ndw_xlt_req_t xlt_req;
    ndw_xlt_resp_t xlt_resp;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    ndw_row_t rows[9] = '{
        '{1'h0, 12'h008, 4'hF, 32'hFFFFFFFF, 32'hFFFFF000},
        '{1'h1, 12'h010, 4'hF, 32'h12345678, 32'h12345000},
        '{1'h0, 12'h00C, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{1'h1, 12'h014, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{1'h0, 12'h018, 4'hF, 32'hFFFFFFFF, 32'hFFFFFFFF},
        '{1'h1, 12'h018, 4'h3, 32'h0000CCDD, 32'hFFFFCCDD},
        '{1'h0, 12'h01C, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{1'h1, 12'h030, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{1'h0, 12'h100, 4'hF, 32'hFFFFFFFF, 32'h00000000}};

    ndw_down_win uut (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .P_REQ(p_req), .P_READY(p_ready),
        .P_RESP(p_resp), .S_REQ(s_req), .S_READY(s_ready), .S_RESP(s_resp),
        .INIT_WE(init_we), .INIT_ADDR(init_addr), .INIT_DATA(init_data), .XLT_REQ(xlt_req),
        .XLT_RESP(xlt_resp), .W2_SETUP(w2_setup), .W3_SETUP(w3_setup),
        .W3_UPPER_SETUP(w3_upper));
    ndw_host host (.clk(ref_clk), .p_req(p_req), .p_ready(p_ready), .p_resp(p_resp),
        .s_req(s_req), .s_ready(s_ready), .s_resp(s_resp));

    // ************************************************
    // Tasks
    // ************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ld(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        init_we = 1'h1;
        init_addr = a;
        init_data = d;
        @(posedge ref_clk);
        #1;
        init_we = 1'h0;
        init_data = ~d;
    endtask : ld

    // Answer is due just after the taking edge, one cycle after the request is driven
    task automatic xl(input logic w3, input logic [31:0] a, input logic [31:0] e, input logic en);
        @(posedge ref_clk);
        #1;
        xlt_req = '{valid: 1'h1, win3: w3, addr: a};
        @(posedge ref_clk);
        #1;
        xlt_req = '{valid: 1'h0, win3: ~w3, addr: ~a};
        chk({31'h0, xlt_resp.valid}, 32'h1);
        chk(xlt_resp.addr, e);
        chk({31'h0, xlt_resp.hit_en}, {31'h0, en});
    endtask : xl

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // ************************************************
    // Clock, timeout and sequence
    // ************************************************
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    // About 100 cycles are needed; the ceiling leaves ample margin
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'h1;
        ce = 1'h1;
        init_we = 1'h0;
        init_addr = 12'h000;
        init_data = 32'h0;
        xlt_req = '0;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        foreach (rows[i]) begin
            host.acc(rows[i].sec, rows[i].a, rows[i].be, rows[i].d, 1'h1, rd, ok);
            chk({31'h0, ok}, 32'h1);
            host.acc(~rows[i].sec, rows[i].a, 4'hF, 32'h0, 1'h0, rd, ok);
            chk(rd, rows[i].e);
        end
        chk(w3_upper, 32'hFFFFCCDD);
        ld(12'h014, 32'h8000F00F);
        chk(w3_setup, 32'h8000F00E);
        ld(12'h00C, 32'h00000002);
        chk(w2_setup, 32'h00000002);
        host.acc(1'h0, 12'h014, 4'hF, 32'h0, 1'h0, rd, ok);
        chk(rd, 32'h8000F00E);
        xl(1'h1, 32'h76543210, 32'h76545210, 1'h1);
        xl(1'h0, 32'h76543210, 32'h76543210, 1'h0);
        ld(12'h00C, 32'hFFFFF002);
        xl(1'h0, 32'h76543210, 32'hFFFFF210, 1'h1);
        // Both ports at once: the secondary must wait, not be lost
        fork
            host.acc(1'h0, 12'h008, 4'hF, 32'h0ABCD000, 1'h1, rd, ok);
            host.acc(1'h1, 12'h010, 4'hF, 32'h00000000, 1'h1, rd2, ok2);
        join
        chk({30'h0, ok, ok2}, 32'h3);
        host.acc(1'h1, 12'h008, 4'hF, 32'h0, 1'h0, rd, ok);
        chk(rd, 32'h0ABCD000);
        // Clock enable low: a loader word must not land
        @(posedge ref_clk);
        #1;
        ce = 1'h0;
        ld(12'h018, 32'h00000000);
        chk(w3_upper, 32'hFFFFCCDD);
        ce = 1'h1;
        @(posedge ref_clk);
        #1;
        rst = 1'h1;
        @(posedge ref_clk);
        #1;
        chk(w2_setup | w3_setup | w3_upper, 32'h0);
        rst = 1'h0;
        host.acc(1'h0, 12'h008, 4'hF, 32'h0, 1'h0, rd, ok);
        chk(rd, 32'h0);
        host.acc(1'h1, 12'h010, 4'hF, 32'h0, 1'h0, rd, ok);
        chk(rd, 32'h0);
        end_of_test();
    end
endmodule : testbench
